// >>> src/phy_management_access.sv
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module phy_management_access #(
   parameter logic [4:0] INTERNAL_PHY_ADDR = 5'h1F
) (
   input  wire logic                      clk_sys,
   input  wire logic                      rst,
   input  wire mgmt_access_pkg::reg_req_t busReq,
   output logic [31:0]                    busRdData,
   output logic                           irqDone,
   output logic                           mdcExt,
   output logic                           mdioExtOut,
   output logic                           mdioExtOe_n,
   input  wire logic                      mdioExtIn,
   output logic                           mdcInt,
   output logic                           mdioIntOut,
   output logic                           mdioIntOe_n,
   input  wire logic                      mdioIntIn
);

   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   mgmt_access_pkg::xfer_state_t state_reg, state_next;
   logic [5:0]  div_reg,       div_next;
   logic        enable_reg,    enable_next;
   logic [31:0] ctrl_reg,      ctrl_next;
   logic [15:0] wrData_reg,    wrData_next;
   logic [15:0] rdValue_reg,   rdValue_next;
   logic [15:0] rdShift_reg,   rdShift_next;
   logic        ready_reg,     ready_next;
   logic        pend_reg,      pend_next;
   logic        irqPend_reg,   irqPend_next;
   logic [5:0]  bitCnt_reg,    bitCnt_next;
   logic [63:0] shift_reg,     shift_next;
   logic        dirRead_reg,   dirRead_next;
   logic        intSel_reg,    intSel_next;
   logic [6:0]  divCnt_reg,    divCnt_next;
   logic        phase_reg,     phase_next;
   logic [31:0] rdData_next;
   logic        mdcExt_next,   mdcInt_next;
   logic        mdoExt_next,   mdoInt_next;
   logic        oeExtN_next,   oeIntN_next;

   logic        mdiExtSync;
   logic        mdiIntSync;
   logic        mdiSel;
   logic [6:0]  halfLen;
   logic        tick;
   logic        driving;
   logic [1:0]  opField;
   logic [4:0]  phyField;
   logic [4:0]  regField;

   // -------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------
   bit_sync #(
      .WIDTH (2)
   ) u_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .din     ({mdioExtIn, mdioIntIn}),
      .dout    ({mdiExtSync, mdiIntSync})
   );

   // -------------------------------------------------------------
   // Next-state logic
   // -------------------------------------------------------------
   always_comb begin
      state_next   = state_reg;
      div_next     = div_reg;
      enable_next  = enable_reg;
      ctrl_next    = ctrl_reg;
      wrData_next  = wrData_reg;
      rdValue_next = rdValue_reg;
      rdShift_next = rdShift_reg;
      ready_next   = ready_reg;
      pend_next    = pend_reg;
      irqPend_next = irqPend_reg;
      bitCnt_next  = bitCnt_reg;
      shift_next   = shift_reg;
      dirRead_next = dirRead_reg;
      intSel_next  = intSel_reg;
      phase_next   = phase_reg;
      rdData_next  = 32'h0000_0000;

      opField  = ctrl_reg[mgmt_access_pkg::CTRL_OP_LSB +: 2];       // [RULE16]
      phyField = ctrl_reg[mgmt_access_pkg::CTRL_PHY_LSB +: 5];
      regField = ctrl_reg[mgmt_access_pkg::CTRL_REG_LSB +: 5];
      mdiSel   = intSel_reg ? mdiIntSync : mdiExtSync;

      // Short divisors are stretched so the clock stays within its limit
      if (({1'b0, div_reg} + 7'd1) < mgmt_access_pkg::MIN_HALF) begin // [RULE3]
         halfLen = mgmt_access_pkg::MIN_HALF;
      end else begin
         halfLen = {1'b0, div_reg} + 7'd1;
      end
      tick = (state_reg == mgmt_access_pkg::ST_RUN) && (divCnt_reg == halfLen - 7'd1);
      if ((state_reg == mgmt_access_pkg::ST_RUN) && !tick) begin
         divCnt_next = divCnt_reg + 7'd1;
      end else begin
         divCnt_next = 7'd0;
      end

      // Clear before set, so a completion in the same cycle survives
      if (busReq.wr && (busReq.addr == mgmt_access_pkg::OFS_IRQ_CLR)
          && busReq.wdata[mgmt_access_pkg::IRQ_DONE_BIT]) begin
         irqPend_next = 1'b0;                                       // [RULE15]
      end

      unique case (state_reg)
         mgmt_access_pkg::ST_IDLE: begin
            phase_next = 1'b0;
            if (pend_reg && enable_reg) begin                       // [RULE18] [RULE11]
               pend_next = 1'b0;
               if ((opField == mgmt_access_pkg::OP_WRITE)
                   || (opField == mgmt_access_pkg::OP_READ)) begin   // [RULE7]
                  shift_next   = {mgmt_access_pkg::PREAMBLE, mgmt_access_pkg::START_CODE,
                                  opField, phyField, regField,
                                  mgmt_access_pkg::TA_WRITE, wrData_reg}; // [RULE17] [RULE4]
                  dirRead_next = (opField == mgmt_access_pkg::OP_READ);
                  intSel_next  = (phyField == INTERNAL_PHY_ADDR);     // [RULE6]
                  bitCnt_next  = 6'd0;
                  ready_next   = 1'b0;
                  state_next   = mgmt_access_pkg::ST_RUN;
               end else begin
                  // Undefined direction codes send nothing and set ready, but raise no done interrupt
                  ready_next = 1'b1;
               end
            end
         end
         mgmt_access_pkg::ST_RUN: begin
            if (tick) begin
               if (!phase_reg) begin
                  phase_next = 1'b1;
                  if (dirRead_reg && (bitCnt_reg >= mgmt_access_pkg::DATA_FIRST)) begin
                     rdShift_next = {rdShift_reg[14:0], mdiSel};      // [RULE5]
                  end
               end else begin
                  phase_next = 1'b0;
                  if (bitCnt_reg == mgmt_access_pkg::LAST_BIT) begin
                     state_next   = mgmt_access_pkg::ST_IDLE;
                     ready_next   = 1'b1;                             // [RULE8]
                     irqPend_next = 1'b1;                             // [RULE9]
                     if (dirRead_reg) begin
                        rdValue_next = rdShift_reg;                   // [RULE12]
                     end
                  end else begin
                     bitCnt_next = bitCnt_reg + 6'd1;
                     shift_next  = {shift_reg[62:0], 1'b0};
                  end
               end
            end
         end
      endcase

      // ----------------------------------------------------------
      // Register bus: never stalls, even mid-transfer
      // ----------------------------------------------------------
      if (busReq.wr) begin                                          // [RULE10]
         unique case (busReq.addr)
            mgmt_access_pkg::OFS_CONFIG: begin
               div_next    = busReq.wdata[mgmt_access_pkg::CFG_DIV_LSB +:
                                          mgmt_access_pkg::CFG_DIV_W];
               enable_next = busReq.wdata[mgmt_access_pkg::CFG_EN_BIT];
            end
            mgmt_access_pkg::OFS_CONTROL: begin
               ctrl_next = busReq.wdata;                            // [RULE11]
               if (busReq.wdata[mgmt_access_pkg::CTRL_INIT_BIT]) begin
                  pend_next = 1'b1;
               end
            end
            mgmt_access_pkg::OFS_WR_DATA: begin
               wrData_next = busReq.wdata[15:0];
            end
            default: begin
            end
         endcase
      end
      if (busReq.rd) begin
         unique case (busReq.addr)
            mgmt_access_pkg::OFS_CONFIG: begin
               rdData_next[mgmt_access_pkg::CFG_DIV_LSB +: mgmt_access_pkg::CFG_DIV_W] = div_reg;
               rdData_next[mgmt_access_pkg::CFG_EN_BIT] = enable_reg;
            end
            mgmt_access_pkg::OFS_CONTROL: begin
               rdData_next = ctrl_reg;
               rdData_next[mgmt_access_pkg::CTRL_RDY_BIT] = ready_reg && !pend_reg; // [RULE8]
            end
            mgmt_access_pkg::OFS_WR_DATA: begin
               rdData_next[15:0] = wrData_reg;
            end
            mgmt_access_pkg::OFS_RD_DATA: begin
               rdData_next[15:0] = rdValue_reg;
            end
            mgmt_access_pkg::OFS_IRQ_STAT: begin
               rdData_next[mgmt_access_pkg::IRQ_DONE_BIT] = irqPend_reg;
            end
            default: begin
               rdData_next = 32'h0000_0000;
            end
         endcase
      end

      // ----------------------------------------------------------
      // Pin drive, from the next frame position
      // ----------------------------------------------------------
      driving     = (state_next == mgmt_access_pkg::ST_RUN)
                    && !(dirRead_next && (bitCnt_next >= mgmt_access_pkg::TA_FIRST)); // [RULE17]
      mdcExt_next = phase_next && !intSel_next;                     // [RULE18]
      mdcInt_next = phase_next && intSel_next;
      mdoExt_next = driving ? shift_next[63] : 1'b1;
      mdoInt_next = driving ? shift_next[63] : 1'b1;
      oeExtN_next = !(driving && !intSel_next);
      oeIntN_next = !(driving && intSel_next);
   end

   // -------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_reg   <= mgmt_access_pkg::ST_IDLE;
         div_reg     <= mgmt_access_pkg::DIV_RST;
         enable_reg  <= 1'b0;
         ctrl_reg    <= mgmt_access_pkg::CTRL_RST;
         wrData_reg  <= 16'h0000;
         rdValue_reg <= 16'h0000;
         rdShift_reg <= 16'h0000;
         ready_reg   <= mgmt_access_pkg::READY_RST;
         pend_reg    <= 1'b0;
         irqPend_reg <= 1'b0;
         bitCnt_reg  <= 6'd0;
         shift_reg   <= 64'h0000_0000_0000_0000;
         dirRead_reg <= 1'b0;
         intSel_reg  <= 1'b0;
         divCnt_reg  <= 7'd0;
         phase_reg   <= 1'b0;
         busRdData   <= 32'h0000_0000;
         irqDone     <= 1'b0;
         mdcExt      <= 1'b0;
         mdcInt      <= 1'b0;
         mdioExtOut  <= 1'b1;
         mdioIntOut  <= 1'b1;
         mdioExtOe_n <= 1'b1;
         mdioIntOe_n <= 1'b1;
      end else begin
         state_reg   <= state_next;
         div_reg     <= div_next;
         enable_reg  <= enable_next;
         ctrl_reg    <= ctrl_next;
         wrData_reg  <= wrData_next;
         rdValue_reg <= rdValue_next;
         rdShift_reg <= rdShift_next;
         ready_reg   <= ready_next;
         pend_reg    <= pend_next;
         irqPend_reg <= irqPend_next;
         bitCnt_reg  <= bitCnt_next;
         shift_reg   <= shift_next;
         dirRead_reg <= dirRead_next;
         intSel_reg  <= intSel_next;
         divCnt_reg  <= divCnt_next;
         phase_reg   <= phase_next;
         busRdData   <= rdData_next;
         irqDone     <= irqPend_next;                               // [RULE9]
         mdcExt      <= mdcExt_next;
         mdcInt      <= mdcInt_next;
         mdioExtOut  <= mdoExt_next;
         mdioIntOut  <= mdoInt_next;
         mdioExtOe_n <= oeExtN_next;
         mdioIntOe_n <= oeIntN_next;
      end
   end

endmodule : phy_management_access

// >>> pkg/mgmt_access_pkg.sv
// Functional notes
// (RULE1) Software sets a valid divisor and the port enable before any transfer.
// (RULE2) Each PHY has its own nonzero 5-bit address; zero is broadcast.
// (RULE3) Generated management clock never exceeds 2.5 MHz.
// (RULE4) Software loads write data, then writes control with initiate to write.
// (RULE5) Control write with initiate starts a read; result lands in read-data register.
// (RULE6) PHY address equal to the internal address parameter uses internal lines.
// (RULE7) Direction field 01 means write, 10 means read.
// (RULE8) Ready flag at control bit 7 sets when the transfer finishes.
// (RULE9) Completion also raises the done interrupt.
// (RULE10) Other registers answer normally while a transfer runs.
// (RULE11) A control write during a transfer is stored and started afterwards.
// (RULE12) A finished read's data is valid even with a request queued behind.
// (RULE13) Software leaves write data alone until the running write completes.
// (RULE14) Software checks the control register before using results or restarting.
// (RULE15) Writing one to the clear bit clears the done interrupt; bit self-clears.
// (RULE16) Control fields: PHY 28:24, register 20:16, direction 15:14, initiate 11, ready 7.
// (RULE17) Frame: preamble, start, direction, addresses, turnaround, 16 data; read releases at turnaround.
// (RULE18) With the port disabled no transfer starts and the clock idles; a frame already running still clocks to its last bit.
package mgmt_access_pkg;

   // -------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------
   localparam int          ADDR_W       = 8;
   localparam logic [7:0]  OFS_CONFIG   = 8'h00;
   localparam logic [7:0]  OFS_CONTROL  = 8'h04;
   localparam logic [7:0]  OFS_WR_DATA  = 8'h08;
   localparam logic [7:0]  OFS_RD_DATA  = 8'h0C;
   localparam logic [7:0]  OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0]  OFS_IRQ_CLR  = 8'h14;

   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int CFG_DIV_LSB   = 0;
   localparam int CFG_DIV_W     = 6;
   localparam int CFG_EN_BIT    = 6;
   localparam int CTRL_PHY_LSB  = 24;
   localparam int CTRL_REG_LSB  = 16;
   localparam int CTRL_OP_LSB   = 14;
   localparam int CTRL_INIT_BIT = 11;
   localparam int CTRL_RDY_BIT  = 7;
   localparam int IRQ_DONE_BIT  = 0;

   // -------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------
   localparam logic [5:0]  DIV_RST   = 6'h00;
   localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
   localparam logic        READY_RST = 1'b1;

   // -------------------------------------------------------------
   // Frame layout
   // -------------------------------------------------------------
   localparam logic [1:0]  OP_WRITE    = 2'b01;
   localparam logic [1:0]  OP_READ     = 2'b10;
   localparam logic [31:0] PREAMBLE    = 32'hFFFF_FFFF;
   localparam logic [1:0]  START_CODE  = 2'b01;
   localparam logic [1:0]  TA_WRITE    = 2'b10;
   localparam logic [5:0]  LAST_BIT    = 6'd63;
   localparam logic [5:0]  TA_FIRST    = 6'd46;
   localparam logic [5:0]  DATA_FIRST  = 6'd48;

   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int         CLK_HZ       = 20_000_000;
   localparam int         MDC_MAX_HZ   = 2_500_000;
   localparam int         MIN_HALF_INT = (CLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ);
   localparam logic [6:0] MIN_HALF     = 7'(MIN_HALF_INT);

   // -------------------------------------------------------------
   // Types
   // -------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

   typedef enum logic {ST_IDLE, ST_RUN} xfer_state_t;

endpackage : mgmt_access_pkg

// >>> src/bit_sync.sv
`timescale 1ns/10ps
module bit_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   // -------------------------------------------------------------
   // Two-stage synchroniser; first stage feeds only the second
   // -------------------------------------------------------------
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] out_next;

   always_comb begin
      meta_next = din;
      out_next  = meta_reg;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         meta_reg <= '1;
         dout     <= '1;
      end else begin
         meta_reg <= meta_next;
         dout     <= out_next;
      end
   end

endmodule : bit_sync

// >>> tb/phy_model.sv
`timescale 1ns/10ps
module phy_model #(
   parameter logic [15:0] RD_VAL = 16'h0000
) (
   input  wire logic        rst,
   input  wire logic        mdc,
   input  wire logic        mdioOut,
   input  wire logic        mdioOe_n,
   output logic             mdioLine,
   output logic [63:0]      frame,
   output logic [7:0]       frames
);
   logic [5:0] bitCnt;
   logic       isRead;
   logic       drv;
   logic       drvBit;
   // Released line floats to the pull-up level, never the stale bit
   assign mdioLine = !mdioOe_n ? mdioOut : (drv ? drvBit : 1'b1);
   always @(posedge mdc or posedge rst) begin
      if (rst) begin
         bitCnt <= 6'h00;
         frame  <= 64'h0000_0000_0000_0000;
         frames <= 8'h00;
         isRead <= 1'b0;
      end else begin
         frame  <= {frame[62:0], mdioLine};
         bitCnt <= bitCnt + 6'h01;
         if (bitCnt == 6'h23) begin
            isRead <= ({frame[0], mdioLine} == mgmt_access_pkg::OP_READ);
         end
         if (bitCnt == 6'h3F) begin
            frames <= frames + 8'h01;
         end
      end
   end
   // Answer on the falling edge so the bit is settled at the next rise
   always @(negedge mdc or posedge rst) begin
      if (rst) begin
         drv    <= 1'b0;
         drvBit <= 1'b1;
      end else begin
         drv    <= isRead && (bitCnt >= 6'h2F);
         drvBit <= (bitCnt == 6'h2F) ? 1'b0 : RD_VAL[6'h3F - bitCnt];
      end
   end
endmodule : phy_model

// >>> tb/phy_management_access_assertions.sv
`timescale 1ns/10ps
module phy_management_access_assertions (
   input wire logic                      clk_sys,
   input wire logic                      rst,
   input wire mgmt_access_pkg::reg_req_t busReq,
   input wire logic [31:0]               busRdData,
   input wire logic                      irqDone,
   input wire logic                      mdcExt,
   input wire logic                      mdioExtOut,
   input wire logic                      mdioExtOe_n,
   input wire logic                      mdioExtIn,
   input wire logic                      mdcInt,
   input wire logic                      mdioIntOut,
   input wire logic                      mdioIntOe_n,
   input wire logic                      mdioIntIn
);
   logic [6:0] frameCnt;
   logic       enMirror;
   logic       anyMdc;
   logic       clrHit;
   assign anyMdc = mdcExt || mdcInt;
   assign clrHit = busReq.wr && busReq.addr == mgmt_access_pkg::OFS_IRQ_CLR && busReq.wdata[0];
   // ----------------------------------------
   // Frame bit counter and enable mirror
   // ----------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         frameCnt <= 7'h00;
         enMirror <= 1'b0;
      end else begin
         if ($fell(mdioExtOe_n) || $fell(mdioIntOe_n)) frameCnt <= 7'h00;
         else if ($rose(anyMdc)) frameCnt <= frameCnt + 7'h01;
         if (busReq.wr && busReq.addr == mgmt_access_pkg::OFS_CONFIG)
            enMirror <= busReq.wdata[mgmt_access_pkg::CFG_EN_BIT];
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   chk_irq_after_frame: assert property (
      $rose(irqDone) |-> frameCnt == 7'h40) else $error("done irq not after 64 bits");
   chk_mdc_high_min: assert property (
      $rose(anyMdc) |=> anyMdc [*3]) else $error("mgmt clock high too short");
   chk_mdc_low_min: assert property (
      $fell(anyMdc) |=> !anyMdc [*3]) else $error("mgmt clock low too short");
   chk_data_on_low: assert property (
      $changed(mdioExtOut) || $changed(mdioIntOut) |-> !anyMdc)
      else $error("data moved while clock high");
   chk_start_preamble: assert property (
      $fell(mdioExtOe_n) |-> mdioExtOut && !mdcExt) else $error("bad frame start");
   chk_start_enabled: assert property (
      $fell(mdioExtOe_n) || $fell(mdioIntOe_n) |-> enMirror) else $error("start while off");
   chk_int_exclusive: assert property (
      !mdioIntOe_n || mdcInt |-> mdioExtOe_n && !mdcExt) else $error("both ports active");
   chk_clear_irq: assert property (
      clrHit |=> !irqDone || $fell(anyMdc)) else $error("irq not cleared");
   chk_stat_read: assert property (
      busReq.rd && busReq.addr == mgmt_access_pkg::OFS_IRQ_STAT
      |=> busRdData == {31'h0000_0000, $past(irqDone)}) else $error("status read wrong");
   chk_rd_idle: assert property (
      !busReq.rd |=> busRdData == 32'h0000_0000) else $error("read data not idle");
   cover property ($rose(irqDone));
   cover property ($fell(mdioIntOe_n));
   cover property (clrHit ##1 !irqDone);
endmodule : phy_management_access_assertions
bind phy_management_access phy_management_access_assertions chk (.clk_sys, .rst, .busReq,
   .busRdData, .irqDone, .mdcExt, .mdioExtOut, .mdioExtOe_n, .mdioExtIn, .mdcInt,
   .mdioIntOut, .mdioIntOe_n, .mdioIntIn);

// >>> tb/phy_management_access_tb.sv
`timescale 1ns/10ps
module phy_management_access_tb;
   localparam logic [4:0]  INT_ADDR = 5'h03;
   localparam logic [15:0] EXT_VAL  = 16'hA5C3;
   localparam logic [15:0] INT_VAL  = 16'h5A3C;
   typedef struct packed {logic [4:0] p; logic [4:0] r; logic [1:0] op; logic [15:0] d;} row_t;
   // Nonzero, distinct addresses only
   row_t rows [6] = '{'{5'h01, 5'h02, 2'h1, 16'hABCD}, '{5'h01, 5'h01, 2'h2, 16'h0000},
      '{INT_ADDR, 5'h04, 2'h1, 16'h1234}, '{INT_ADDR, 5'h05, 2'h2, 16'h0000},
      '{5'h02, 5'h06, 2'h0, 16'h0000}, '{5'h02, 5'h07, 2'h3, 16'h0000}};
   logic                      clk_sys, rst, irqDone, isInt, go;
   mgmt_access_pkg::reg_req_t busReq;
   logic [31:0]               busRdData, rv;
   logic                      mdcExt, mdioExtOut, mdioExtOe_n, mdioExtIn;
   logic                      mdcInt, mdioIntOut, mdioIntOe_n, mdioIntIn;
   logic [63:0]               extFrame, intFrame;
   logic [7:0]                extN, intN;
   logic [15:0]               lastRd;
   int                        err_total, samples_checked, nExt, nInt, i;
   phy_management_access #(.INTERNAL_PHY_ADDR(INT_ADDR)) dut (.clk_sys, .rst, .busReq,
      .busRdData, .irqDone, .mdcExt, .mdioExtOut, .mdioExtOe_n, .mdioExtIn, .mdcInt,
      .mdioIntOut, .mdioIntOe_n, .mdioIntIn);
   phy_model #(.RD_VAL(EXT_VAL)) extPhy (.rst, .mdc(mdcExt), .mdioOut(mdioExtOut),
      .mdioOe_n(mdioExtOe_n), .mdioLine(mdioExtIn), .frame(extFrame), .frames(extN));
   phy_model #(.RD_VAL(INT_VAL)) intPhy (.rst, .mdc(mdcInt), .mdioOut(mdioIntOut),
      .mdioOe_n(mdioIntOe_n), .mdioLine(mdioIntIn), .frame(intFrame), .frames(intN));
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // ----------------------------------------
   // Bus tasks and checks
   // ----------------------------------------
   task automatic cmp(input logic [63:0] got, input logic [63:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : cmp
   task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      busReq.addr  <= a;
      busReq.wdata <= d;
      busReq.wr    <= 1'b1;
      @(posedge clk_sys);
      busReq.wr <= 1'b0;
   endtask : wrReg
   task automatic rdReg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      busReq.addr <= a;
      busReq.rd   <= 1'b1;
      @(posedge clk_sys);
      busReq.rd <= 1'b0;
      @(negedge clk_sys);
      d = busRdData;
   endtask : rdReg
   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   task automatic timeOut(input logic ok);
      if (!ok) begin
         err_total++;
         $display("CHECK FAILED t=%0t wait ran out", $time);
         test_done();
      end
   endtask : timeOut
   // Poll the ready flag before using any result
   task automatic waitDone(output logic [31:0] c);
      c = 32'h0000_0000;
      for (int j = 0; j < 800 && c[7] !== 1'b1; j++) rdReg(mgmt_access_pkg::OFS_CONTROL, c);
      timeOut(c[7] === 1'b1);
   endtask : waitDone
   function automatic logic [31:0] ctlWord(input logic [4:0] p, r, input logic [1:0] op);
      return {3'h0, p, 3'h0, r, op, 2'h0, 1'b1, 11'h000};
   endfunction : ctlWord
   function automatic logic [63:0] expFrame(input logic [4:0] p, r, input logic [1:0] op,
                                            input logic [15:0] d);
      return {32'hFFFF_FFFF, 2'h1, op, p, r, 2'h2, d};
   endfunction : expFrame
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      busReq = '0;
      rst = 1'b1;
      err_total = 0;
      samples_checked = 0;
      nExt = 0;
      nInt = 0;
      lastRd = 16'h0000;
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      rdReg(mgmt_access_pkg::OFS_CONTROL, rv);
      cmp(rv, 32'h0000_0080, "control reset");
      rdReg(8'h20, rv);
      cmp(rv, 32'h0000_0000, "unmapped read");
      $display("reset test done");
      wrReg(mgmt_access_pkg::OFS_CONTROL, ctlWord(5'h01, 5'h03, mgmt_access_pkg::OP_WRITE));
      repeat (40) @(posedge clk_sys);
      rdReg(mgmt_access_pkg::OFS_CONTROL, rv);
      cmp({extN, rv[7]}, 9'h000, "held while off");
      wrReg(mgmt_access_pkg::OFS_CONFIG, 32'h0000_0040);
      waitDone(rv);
      cmp(extFrame, expFrame(5'h01, 5'h03, 2'h1, 16'h0000), "held frame");
      nExt++;
      wrReg(mgmt_access_pkg::OFS_CONFIG, 32'h0000_0043);
      $display("enable test done");
      foreach (rows[k]) begin
         isInt = rows[k].p == INT_ADDR;
         go = rows[k].op == mgmt_access_pkg::OP_WRITE || rows[k].op == mgmt_access_pkg::OP_READ;
         if (rows[k].op == mgmt_access_pkg::OP_READ) lastRd = isInt ? INT_VAL : EXT_VAL;
         nExt += (go && !isInt);
         nInt += (go && isInt);
         wrReg(mgmt_access_pkg::OFS_WR_DATA, {16'h0000, rows[k].d});
         wrReg(mgmt_access_pkg::OFS_CONTROL, ctlWord(rows[k].p, rows[k].r, rows[k].op));
         waitDone(rv);
         cmp(rv, ctlWord(rows[k].p, rows[k].r, rows[k].op) | 32'h0000_0080, "ctl");
         cmp({extN, intN}, {nExt[7:0], nInt[7:0]}, "frame counts");
         if (go) cmp(isInt ? intFrame : extFrame, expFrame(rows[k].p, rows[k].r, rows[k].op,
            rows[k].op == mgmt_access_pkg::OP_READ ? lastRd : rows[k].d), "frame");
         rdReg(mgmt_access_pkg::OFS_RD_DATA, rv);
         cmp(rv, {16'h0000, lastRd}, "read data");
         rdReg(mgmt_access_pkg::OFS_IRQ_STAT, rv);
         cmp(rv, {31'h0000_0000, go}, "done irq");
         wrReg(mgmt_access_pkg::OFS_IRQ_CLR, 32'h0000_0001);
         rdReg(mgmt_access_pkg::OFS_IRQ_CLR, rv);
         cmp({rv, irqDone}, 33'h0_0000_0000, "irq clear");
         $display("row %0d done", k);
      end
      // Write data loaded before the read, never during a write frame
      wrReg(mgmt_access_pkg::OFS_WR_DATA, 32'h0000_0F0F);
      wrReg(mgmt_access_pkg::OFS_CONTROL, ctlWord(5'h01, 5'h08, mgmt_access_pkg::OP_READ));
      repeat (20) @(posedge clk_sys);
      wrReg(mgmt_access_pkg::OFS_CONTROL, ctlWord(5'h02, 5'h09, mgmt_access_pkg::OP_WRITE));
      rdReg(mgmt_access_pkg::OFS_CONFIG, rv);
      cmp(rv, 32'h0000_0043, "config mid frame");
      for (i = 0; i < 2000 && irqDone !== 1'b1; i++) @(negedge clk_sys);
      timeOut(irqDone === 1'b1);
      rdReg(mgmt_access_pkg::OFS_RD_DATA, rv);
      cmp(rv, {16'h0000, EXT_VAL}, "first read kept");
      rdReg(mgmt_access_pkg::OFS_CONTROL, rv);
      cmp(rv[7], 1'b0, "queued busy");
      waitDone(rv);
      cmp(extN, nExt[7:0] + 8'h02, "two frames");
      cmp(extFrame, expFrame(5'h02, 5'h09, 2'h1, 16'h0F0F), "queued frame");
      $display("queue test done");
      test_done();
   end
endmodule : phy_management_access_tb
